// ===== include/oaf_defs.svh
// Constants for the oversampling average filter
`ifndef OAF_DEFS_SVH
`define OAF_DEFS_SVH

// ****************************************************
// Register offsets
// ****************************************************
`define OAF_CTRL_OFF     12'h000
`define OAF_STATUS_OFF   12'h004
`define OAF_RESULT0_OFF  12'h010
`define OAF_RESULT7_OFF  12'h02c

// ****************************************************
// Field positions and reset values
// ****************************************************
`define OAF_CTRL_EN_BIT     0
`define OAF_CTRL_RESET      32'h0000_0001
`define OAF_ST_BUSY_BIT     0
`define OAF_ST_READY_BIT    1
`define OAF_ST_BADOS_BIT    2
`define OAF_ST_REFINT_BIT   3
`define OAF_ST_OVERRUN_BIT  8
`define OAF_ST_RATIO_LSB    4

// ****************************************************
// Ratio codes and timing
// ****************************************************
`define OAF_OS_NONE         3'h0
`define OAF_OS_INVALID      3'h7
`define OAF_CLK_PERIOD_NS   10
`define OAF_SAMPLE_PERIOD_NS 2000
`define OAF_SAMPLE_CYCLES \
    ((`OAF_SAMPLE_PERIOD_NS + `OAF_CLK_PERIOD_NS - 1) / `OAF_CLK_PERIOD_NS)

`endif

// ===== include/oaf_pkg.sv
// Types for the oversampling average filter
package oaf_pkg;
    typedef enum logic [1:0] {
        OAF_IDLE,
        OAF_CONVERT,
        OAF_SPACE
    } oaf_state_t;
endpackage

// ===== logic/oaf_accum.sv
// One channel of sum-and-shift averaging
`timescale 1ns/100ps
module oaf_accum #(
    parameter int DW = 16,
    parameter int SW = 22
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          clear,
    input  wire logic          add,
    input  wire logic [DW-1:0] sample,
    input  wire logic [2:0]    shift,
    output logic      [DW-1:0] average
);
    logic signed [SW-1:0] sum;
    wire  signed [SW-1:0] sample_ext = SW'(signed'(sample));
    // Fold in a sample arriving this cycle so the caller can publish at once;
    // shifting a truncated average back up would lose the low sum bits
    wire  signed [SW-1:0] sum_now    = add ? sum + sample_ext : sum;
    wire  signed [SW-1:0] shifted    = sum_now >>> shift;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sum <= '0;
        end else if (clear) begin
            sum <= '0;
        end else if (add) begin
            sum <= sum + sample_ext;
        end
    end

    // Arithmetic shift floors toward negative infinity
    assign average = shifted[DW-1:0];

    sum_step_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        add && !clear |=> sum - $past(sum) == $past(sample_ext))
        else $error("Sample not added to the running sum");
endmodule // oaf_accum

// ===== logic/oaf_filter.sv
// Oversampling average filter with AHB-Lite status and result registers
`timescale 1ns/100ps
`include "oaf_defs.svh"

//
// Function
// - Ratio select 000 means no oversampling, 001..110 mean 2..64, 111 is refused.
// - In oversampling mode the first sample follows the start-pin rising edge.
// - Later samples of a sequence use an internal strobe, not further edges.
// - Each channel's samples are averaged over the selected ratio.
// - One 16-bit word per channel is produced per oversampled conversion.
// - Throughput per channel falls with the ratio, 500 kSPS down to 7.8125.
// - Reference select high picks internal, low picks external reference.
// - Results are 16-bit two's complement for every channel and range.
module oaf_filter #(
    parameter int CH = 8,
    parameter int DW = 16,
    parameter int SAMPLE_CYCLES = `OAF_SAMPLE_CYCLES
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic                hresp,
    output logic      [31:0]    hrdata,
    input  wire logic [2:0]     oversample_ratio_select,
    input  wire logic           convert_start_group_a,
    input  wire logic           convert_start_group_b,
    input  wire logic           reference_source_select,
    output logic                reference_internal_enable,
    output logic                conv_start,
    output logic      [1:0]     conv_group,
    input  wire logic           conv_done,
    input  wire logic [CH*DW-1:0] conv_data
);
    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [1:0] start_prev;
    wire  [5:0] pin_raw = {reference_source_select, convert_start_group_b,
                           convert_start_group_a, oversample_ratio_select};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Reference bit rests high so the reference output does not
            // dip for two cycles after reset
            pin_meta   <= 6'h20;
            pin_sync   <= 6'h20;
            start_prev <= 2'h0;
        end else begin
            pin_meta   <= pin_raw;
            pin_sync   <= pin_meta;
            start_prev <= pin_sync[4:3];
        end
    end

    wire [2:0] ratio_sel = pin_sync[2:0];
    wire [1:0] start_rise = pin_sync[4:3] & ~start_prev;
    wire       ref_sync = pin_sync[5];

    // ****************************************************
    // Sequencer
    // ****************************************************
    oaf_pkg::oaf_state_t state;
    oaf_pkg::oaf_state_t next_state;
    logic        ctrl_enable;
    logic [2:0]  ratio_q;
    logic [6:0]  sample_cnt;
    logic [15:0] period_cnt;
    logic        result_ready;
    logic        overrun;
    logic [DW-1:0] result [CH];

    wire os_bad   = ratio_sel == `OAF_OS_INVALID;
    wire os_on    = ratio_sel != `OAF_OS_NONE;
    wire any_edge = |start_rise;
    // Refusing edges inside the sample period caps throughput
    wire period_done = period_cnt >= 16'(SAMPLE_CYCLES - 1);
    wire trigger  = (state == oaf_pkg::OAF_IDLE) && ctrl_enable && !os_bad
                    && period_done && any_edge;
    wire rejected = any_edge && !trigger && !os_bad && ctrl_enable;
    wire [6:0] total = 7'h01 << ratio_q;
    wire last_sample = sample_cnt == total - 7'h01;
    wire take     = (state == oaf_pkg::OAF_CONVERT) && conv_done;
    wire publish  = take && last_sample;
    wire strobe   = (state == oaf_pkg::OAF_SPACE) && period_done;
    // Edges while oversampling are tied; one edge serves both groups
    wire [1:0] next_group = os_on ? 2'h3 : start_rise;

    always_comb begin
        next_state = state;
        unique case (state)
            oaf_pkg::OAF_IDLE:
                if (trigger) next_state = oaf_pkg::OAF_CONVERT;
            oaf_pkg::OAF_CONVERT:
                if (take) begin
                    next_state = last_sample ? oaf_pkg::OAF_IDLE
                                             : oaf_pkg::OAF_SPACE;
                end
            oaf_pkg::OAF_SPACE:
                if (strobe) next_state = oaf_pkg::OAF_CONVERT;
            default:
                next_state = oaf_pkg::OAF_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= oaf_pkg::OAF_IDLE;
            conv_start <= 1'b0;
            conv_group <= 2'h0;
            ratio_q    <= `OAF_OS_NONE;
            sample_cnt <= 7'h00;
        end else begin
            state      <= next_state;
            conv_start <= trigger || strobe;
            if (trigger) begin
                conv_group <= next_group;
                ratio_q    <= ratio_sel;
                sample_cnt <= 7'h00;
            end else if (take) begin
                sample_cnt <= sample_cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_cnt <= 16'(SAMPLE_CYCLES);
        end else if (trigger || strobe) begin
            period_cnt <= 16'h0000;
        end else if (!period_done) begin
            period_cnt <= period_cnt + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reference_internal_enable <= 1'b1;
        end else begin
            reference_internal_enable <= ref_sync;
        end
    end

    // ****************************************************
    // Channel averaging
    // ****************************************************
    logic [DW-1:0] average [CH];

    for (genvar c = 0; c < CH; c++) begin : g_ch
        wire in_group = conv_group[c / (CH / 2)];
        oaf_accum #(.DW(DW), .SW(DW + 6)) u_acc (
            .hclk    (hclk),
            .hresetn (hresetn),
            .clear   (trigger),
            .add     (take && in_group),
            .sample  (conv_data[c*DW +: DW]),
            .shift   (ratio_q),
            .average (average[c])
        );
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                result[c] <= '0;
            end else if (publish && in_group) begin
                result[c] <= average[c];
            end
        end
    end

    // ****************************************************
    // AHB-Lite slave
    // ****************************************************
    logic        wr_pend;
    logic [11:0] wr_addr;
    wire         addr_ok = hsel && hready && htrans[1];
    wire [11:0]  a = haddr[11:0];
    wire         wr_ctrl   = wr_pend && wr_addr == `OAF_CTRL_OFF;
    wire         wr_status = wr_pend && wr_addr == `OAF_STATUS_OFF;
    wire         in_results = a >= `OAF_RESULT0_OFF
                              && a <= `OAF_RESULT7_OFF;
    wire [2:0]   res_idx = 3'((a - `OAF_RESULT0_OFF) >> 2);
    wire [31:0]  status_word = {23'h000000, overrun, 1'b0, ratio_sel,
                                reference_internal_enable, os_bad,
                                result_ready,
                                state != oaf_pkg::OAF_IDLE};
    wire [31:0]  rd_mux = (a == `OAF_CTRL_OFF) ? {31'h0, ctrl_enable}
                        : (a == `OAF_STATUS_OFF) ? status_word
                        : in_results ? {16'h0000, result[res_idx]}
                        : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok) wr_addr <= a;
            if (addr_ok && !hwrite) hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_enable  <= 1'(`OAF_CTRL_RESET);
            result_ready <= 1'b0;
            overrun      <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_enable <= hwdata[`OAF_CTRL_EN_BIT];
            // Set wins over a write-one clear in the same cycle
            result_ready <= publish || (result_ready &&
                !(wr_status && hwdata[`OAF_ST_READY_BIT]));
            overrun <= rejected || (overrun &&
                !(wr_status && hwdata[`OAF_ST_OVERRUN_BIT]));
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************************
    // Checks
    // ****************************************************
    // Launches counted apart from the sample counter, so a slip in
    // either one shows up as a mismatch
    logic [6:0] launches;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            launches <= 7'h00;
        end else if (trigger) begin
            launches <= 7'h01;
        end else if (strobe) begin
            launches <= launches + 7'h01;
        end
    end

    sequence seq_launch;
        trigger ##1 conv_start;
    endsequence

    start_on_edge_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        trigger |-> seq_launch)
        else $error("Edge did not launch a conversion");

    invalid_refused_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        state == oaf_pkg::OAF_IDLE && os_bad |=> !conv_start)
        else $error("Invalid ratio code started a sequence");

    strobe_spacing_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        conv_start |=> (!conv_start)[*8])
        else $error("Sampling strobes too close");

    sample_count_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        publish |-> launches == (7'h01 << ratio_q)
                    && ratio_q != `OAF_OS_INVALID)
        else $error("Result published after wrong sample count");

    single_result_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        publish |=> state == oaf_pkg::OAF_IDLE && !publish ##1 !publish)
        else $error("More than one result per conversion");

    ready_after_pub_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        publish |=> result_ready)
        else $error("Result ready flag lost");

    ref_follows_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        $changed(ref_sync) |=> reference_internal_enable == $past(ref_sync))
        else $error("Reference select not followed");

    busy_ignores_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        state != oaf_pkg::OAF_IDLE && any_edge && ctrl_enable && !os_bad
        |=> overrun && $stable(ratio_q))
        else $error("External edge restarted a running sequence");

    no_os_single_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        take && ratio_q == `OAF_OS_NONE |-> publish)
        else $error("No-oversampling conversion took more than one sample");

    group_tied_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        trigger && os_on |=> conv_group == 2'h3)
        else $error("Oversampled conversion left a group out");

    result_hold_a: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !publish |=> $stable(result[0]) && $stable(result[CH-1]))
        else $error("Result changed without a finished conversion");
endmodule // oaf_filter

// ===== testbench/oaf_core_model.sv
// Behavioural converter core that answers each sample request
`timescale 1ns/100ps
module oaf_core_model #(
    parameter int CH = 8,
    parameter int DW = 16
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             conv_start,
    input  wire logic             slow,
    output logic                  conv_done,
    output logic      [CH*DW-1:0] conv_data
);
    int               n;
    int               wait_c;
    logic [CH*DW-1:0] word;
    // Inverse outside the answer cycle so stale data is never reused
    assign conv_data = conv_done ? word : ~word;
    always_comb begin
        for (int c = 0; c < CH; c++) begin
            word[c*DW +: DW] = 16'h8000 + 16'(n) * 16'h0357
                + 16'(c) * 16'h1111;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_c    <= 0;
            n         <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (wait_c == 1);
            if (conv_done)
                n <= n + 1;
            if (conv_start)
                wait_c <= slow ? 9 : 1;
            else if (wait_c > 0)
                wait_c <= wait_c - 1;
        end
    end
endmodule // oaf_core_model

// ===== testbench/tb_top.sv
// Self-checking testbench for the oversampling average filter
`timescale 1ns/100ps
`include "oaf_defs.svh"
module tb_top;
    localparam int SC = 20;
    logic         hclk = 1'b0;
    logic         hresetn;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [31:0]  hwdata;
    logic         hready;
    logic         hresp;
    logic [31:0]  hrdata;
    logic [2:0]   os_sel;
    logic         st_a;
    logic         st_b;
    logic         ref_sel;
    logic         ref_int;
    logic         conv_start;
    logic [1:0]   conv_group;
    logic         conv_done;
    logic [127:0] conv_data;
    logic         slow;
    int           errors = 0;
    int           n_tests = 0;
    int           cyc = 0;
    int           n_starts = 0;
    int           n_done = 0;
    int           last_st = -100000;
    int           min_gap = 100000;
    logic [15:0]  exp_ch4 = 16'h0000;

    always #5 hclk = ~hclk;

    oaf_filter #(.SAMPLE_CYCLES(SC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .oversample_ratio_select(os_sel),
        .convert_start_group_a(st_a), .convert_start_group_b(st_b),
        .reference_source_select(ref_sel),
        .reference_internal_enable(ref_int), .conv_start(conv_start),
        .conv_group(conv_group), .conv_done(conv_done),
        .conv_data(conv_data));

    oaf_core_model core (
        .hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

    // ****************************************************
    // Shared tasks
    // ****************************************************
    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Start pins rise as given (both together when oversampling), then fall together
    task automatic kick(input logic a, input logic b);
        st_a <= a;
        st_b <= b;
        repeat (4) @(posedge hclk);
        st_a <= 1'b0;
        st_b <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic wait_ready(output logic [31:0] v);
        v = 32'h0;
        for (int i = 0; i < 3000 && v[1] !== 1'b1; i++)
            ahb(1'b0, `OAF_STATUS_OFF, 32'h0, v);
    endtask

    function automatic logic [15:0] samp(int c, int k);
        return 16'h8000 + 16'(k) * 16'h0357 + 16'(c) * 16'h1111;
    endfunction

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) begin
            n_starts <= n_starts + 1;
            last_st  <= cyc;
            if (cyc - last_st < min_gap)
                min_gap <= cyc - last_st;
        end
        if (conv_done === 1'b1)
            n_done <= n_done + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_regs();
        logic [31:0] v;
        int          s0;
        check(32'(ref_int), 32'h1);
        ahb(1'b0, `OAF_CTRL_OFF, 32'h0, v);
        check(v, `OAF_CTRL_RESET);
        check(32'(hresp), 32'h0);
        ahb(1'b0, 32'h100, 32'h0, v);
        check(v, 32'h0);
        ahb(1'b1, `OAF_CTRL_OFF, 32'h0, v);
        s0 = n_starts;
        kick(1'b1, 1'b1);
        repeat (10) @(posedge hclk);
        check(32'(n_starts - s0), 32'h0);
        ahb(1'b1, `OAF_CTRL_OFF, 32'h1, v);
        repeat (SC) @(posedge hclk);
    endtask

    task automatic t_ref();
        logic [31:0] v;
        ref_sel <= 1'b0;
        repeat (5) @(posedge hclk);
        check(32'(ref_int), 32'h0);
        ahb(1'b0, `OAF_STATUS_OFF, 32'h0, v);
        check(32'(v[3]), 32'h0);
        ref_sel <= 1'b1;
        repeat (5) @(posedge hclk);
        check(32'(ref_int), 32'h1);
    endtask

    task automatic t_ratio(input logic [2:0] code, input logic twice);
        logic [31:0] v;
        int          n0;
        int          s0;
        int          s;
        os_sel <= code;
        slow   <= code[0];
        repeat (5) @(posedge hclk);
        n0 = n_done;
        s0 = n_starts;
        kick(1'b1, 1'b1);
        if (twice)
            kick(1'b1, 1'b1);
        wait_ready(v);
        check(32'(v[6:4]), 32'(code));
        check(32'(v[8]), 32'(twice));
        check(32'(n_starts - s0), 32'(1 << code));
        for (int c = 0; c < 8; c++) begin
            s = 0;
            for (int k = 0; k < (1 << code); k++)
                s += int'($signed(samp(c, n0 + k)));
            ahb(1'b0, `OAF_RESULT0_OFF + 4 * c, 32'h0, v);
            check(v, {16'h0000, 16'(s >>> code)});
            if (c == 4)
                exp_ch4 = 16'(s >>> code);
        end
        ahb(1'b1, `OAF_STATUS_OFF, 32'h0000_0102, v);
        ahb(1'b0, `OAF_STATUS_OFF, 32'h0, v);
        check(32'({v[8], v[1]}), 32'h0);
        repeat (SC) @(posedge hclk);
    endtask

    task automatic t_bad();
        logic [31:0] v;
        int          s0;
        os_sel <= `OAF_OS_INVALID;
        repeat (5) @(posedge hclk);
        ahb(1'b0, `OAF_STATUS_OFF, 32'h0, v);
        check(32'(v[2]), 32'h1);
        s0 = n_starts;
        kick(1'b1, 1'b1);
        repeat (30) @(posedge hclk);
        check(32'(n_starts - s0), 32'h0);
    endtask

    task automatic t_group();
        logic [31:0] v;
        int          n0;
        os_sel <= `OAF_OS_NONE;
        repeat (5) @(posedge hclk);
        n0 = n_done;
        kick(1'b1, 1'b0);
        wait_ready(v);
        check(32'(conv_group), 32'h1);
        ahb(1'b0, `OAF_RESULT0_OFF, 32'h0, v);
        check(v, {16'h0000, samp(0, n0)});
        ahb(1'b0, `OAF_RESULT0_OFF + 32'h10, 32'h0, v);
        check(v, {16'h0000, exp_ch4});
    endtask

    initial begin
        hresetn = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hwdata  = 32'h0;
        os_sel  = 3'h0;
        st_a    = 1'b0;
        st_b    = 1'b0;
        ref_sel = 1'b1;
        slow    = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_ref();
        for (int i = 0; i < 7; i++)
            t_ratio(3'(i), 1'b0);
        t_ratio(3'h2, 1'b1);
        t_bad();
        t_group();
        check(32'(min_gap >= SC), 32'h1);
        report_and_stop();
    end
endmodule // tb_top
